// ---- hdl/ilpc_regs.svh ----
`ifndef ILPC_REGS_SVH
`define ILPC_REGS_SVH
// ****************************************
// idle request framing
// ****************************************
`define ILPC_CMD_IDLE 8'h07
`define ILPC_IDLE_LEN 8'h0e
`define ILPC_IDLE_LAST 4'hd
`define ILPC_EXTRA_FIRST 4'h7
`define ILPC_SLEEP_EXTRA_IDX 4'h8
`define ILPC_RES_OK 8'h00
`define ILPC_RES_LEN1 8'h01
`define ILPC_ERR_LEN 8'h82
`define ILPC_ERR_LEN0 8'h00
// ****************************************
// wake sources and settings
// ****************************************
`define ILPC_WS_FIELD 8'h04
`define ILPC_WS_PIN 8'h08
`define ILPC_WS_FIELD_BIT 2
`define ILPC_WS_FIELD_ALT_BIT 1
`define ILPC_WS_PIN_BIT 3
`define ILPC_ENTRY_HIBERNATE 16'h0400
`define ILPC_ENTRY_SLEEP_FD 16'h0142
`define ILPC_ENTRY_SLEEP 16'h0100
`define ILPC_WAKE_HIBERNATE 16'h0400
`define ILPC_WAKE_SLEEP 16'h3800
`define ILPC_LEAVE_DEFAULT 16'h1800
`define ILPC_EXTRA_DEFAULT 8'h60
// ****************************************
// timing
// ****************************************
`define ILPC_CLK_PERIOD_NS 5
`define ILPC_T3_NS 6000000
`define ILPC_WAKE_PULSE_CYC 8
// ****************************************
// host register offsets and fields
// ****************************************
`define ILPC_OFF_CTRL 8'h00
`define ILPC_OFF_WSRC 8'h04
`define ILPC_OFF_ENTRY 8'h08
`define ILPC_OFF_WAKE 8'h0c
`define ILPC_OFF_LEAVE 8'h10
`define ILPC_OFF_EXTRA 8'h14
`define ILPC_OFF_STATUS 8'h18
`define ILPC_OFF_IRQ_STAT 8'h1c
`define ILPC_OFF_IRQ_MASK 8'h20
`define ILPC_CTRL_SEND_BIT 0
`define ILPC_CTRL_PULSE_BIT 1
`define ILPC_IRQ_REPLY_BIT 0
`define ILPC_IRQ_ERROR_BIT 1
`endif

// ---- hdl/ilpc_pkg.sv ----
package ilpc_pkg;
  typedef enum logic [2:0] {
    DEV_PWRUP, DEV_START, DEV_READY, DEV_LEN, DEV_DATA, DEV_SKIP, DEV_WAIT
  } ilpc_dev_state_e;
  typedef enum logic [1:0] {
    HST_IDLE, HST_SEND, HST_WAIT
  } ilpc_host_state_e;
  typedef logic [7:0] ilpc_byte_t;
endpackage

// ---- hdl/ilpc_link_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface ilpc_link_if;
  logic hToDValid;
  logic [7:0] hToDData;
  logic dToHValid;
  logic [7:0] dToHData;
  logic wakeReqN;
  modport dev (input hToDValid, input hToDData, input wakeReqN,
    output dToHValid, output dToHData);
  modport host (output hToDValid, output hToDData, output wakeReqN,
    input dToHValid, input dToHData);
endinterface
`default_nettype wire

// ---- hdl/ilpc_device.sv ----
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "ilpc_regs.svh"
module ilpc_device
  import ilpc_pkg::*;
#(
  parameter int unsigned STARTUP_CYCLES = `ILPC_T3_NS / `ILPC_CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic rst,
  ilpc_link_if.dev link,
  input wire logic fieldPresent,
  output logic hostReady,
  output logic lowPower,
  output logic hibernate,
  output logic fieldDetOn,
  output logic [7:0] wakeSource,
  output logic [15:0] entrySetting,
  output logic [15:0] wakeSetting,
  output logic [15:0] leaveSetting,
  output logic [55:0] extraParams
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic pinMeta_reg, pinSync_reg, pinPrev_reg;
  logic fieldMeta_reg, fieldSync_reg;
  logic pinPulse;

  always_ff @(posedge clk) begin
    if (rst) begin
      pinMeta_reg <= 1'b1;
      pinSync_reg <= 1'b1;
      pinPrev_reg <= 1'b1;
    end else begin
      pinMeta_reg <= link.wakeReqN;
      pinSync_reg <= pinMeta_reg;
      pinPrev_reg <= pinSync_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fieldMeta_reg <= 1'b0;
      fieldSync_reg <= 1'b0;
    end else begin
      fieldMeta_reg <= fieldPresent;
      fieldSync_reg <= fieldMeta_reg;
    end
  end

  // low pulse counted on its rising end
  assign pinPulse = pinSync_reg & ~pinPrev_reg;

  // ****************************************
  // request parser
  // ****************************************
  ilpc_dev_state_e state_reg;
  logic [7:0] cmd_reg;
  logic [7:0] left_reg;
  logic [3:0] idx_reg;
  logic [20:0] startCnt_reg;
  logic hib_reg;
  ilpc_byte_t data_reg [0:13];
  logic fieldEn, pinEn, wakeByPin, wakeByField;
  logic loadErr, loadWake;
  logic [7:0] wakeFlag;

  // both printed bit spellings of the field source are honoured
  assign fieldEn = data_reg[0][`ILPC_WS_FIELD_BIT] |
    data_reg[0][`ILPC_WS_FIELD_ALT_BIT];
  assign pinEn = data_reg[0][`ILPC_WS_PIN_BIT];
  assign wakeByPin = pinPulse & (pinEn | hib_reg);
  assign wakeByField = fieldSync_reg & fieldEn & ~hib_reg;
  // pin wins when both arrive together
  assign wakeFlag = wakeByPin ? `ILPC_WS_PIN : `ILPC_WS_FIELD;

  always_comb begin
    loadErr = 1'b0;
    loadWake = 1'b0;
    case (state_reg)
      DEV_LEN: begin
        loadErr = link.hToDValid && cmd_reg == `ILPC_CMD_IDLE &&
          link.hToDData != `ILPC_IDLE_LEN && link.hToDData == 8'h00;
      end
      DEV_SKIP: begin
        loadErr = link.hToDValid && left_reg == 8'h01 &&
          cmd_reg == `ILPC_CMD_IDLE;
      end
      DEV_WAIT: begin
        loadWake = wakeByPin | wakeByField;
      end
      default: begin
        loadErr = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= DEV_PWRUP;
      cmd_reg <= 8'h00;
      left_reg <= 8'h00;
      idx_reg <= 4'h0;
      startCnt_reg <= 21'h000000;
    end else begin
      case (state_reg)
        DEV_PWRUP: begin
          if (pinPulse) begin
            state_reg <= DEV_START;
            startCnt_reg <= 21'h000000;
          end
        end
        DEV_START: begin
          if (startCnt_reg == 21'(STARTUP_CYCLES - 1)) begin
            state_reg <= DEV_READY;
          end else begin
            startCnt_reg <= startCnt_reg + 21'h000001;
          end
        end
        DEV_READY: begin
          if (link.hToDValid) begin
            cmd_reg <= link.hToDData;
            state_reg <= DEV_LEN;
          end
        end
        DEV_LEN: begin
          if (link.hToDValid) begin
            left_reg <= link.hToDData;
            idx_reg <= 4'h0;
            if (cmd_reg == `ILPC_CMD_IDLE && link.hToDData == `ILPC_IDLE_LEN) begin
              state_reg <= DEV_DATA;
            end else if (link.hToDData == 8'h00) begin
              state_reg <= DEV_READY;
            end else begin
              // other commands and bad lengths are drained, not decoded
              state_reg <= DEV_SKIP;
            end
          end
        end
        DEV_SKIP: begin
          if (link.hToDValid) begin
            left_reg <= left_reg - 8'h01;
            if (left_reg == 8'h01) begin
              state_reg <= DEV_READY;
            end
          end
        end
        DEV_DATA: begin
          if (link.hToDValid) begin
            idx_reg <= idx_reg + 4'h1;
            if (idx_reg == `ILPC_IDLE_LAST) begin
              state_reg <= DEV_WAIT;
            end
          end
        end
        DEV_WAIT: begin
          if (loadWake) begin
            state_reg <= DEV_READY;
          end
        end
        default: begin
          state_reg <= DEV_PWRUP;
        end
      endcase
    end
  end

  // ****************************************
  // request storage
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 14; i++) begin
        data_reg[i] <= 8'h00;
      end
      data_reg[5] <= 8'(`ILPC_LEAVE_DEFAULT >> 8);
    end else if (state_reg == DEV_DATA && link.hToDValid) begin
      data_reg[idx_reg] <= link.hToDData;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hib_reg <= 1'b0;
    end else if (state_reg == DEV_DATA && link.hToDValid && idx_reg == 4'h2) begin
      hib_reg <= {data_reg[1], link.hToDData} == `ILPC_ENTRY_HIBERNATE;
    end
  end

  // ****************************************
  // reply sender
  // ****************************************
  logic [1:0] txLeft_reg;
  ilpc_byte_t txBuf_reg [0:2];
  logic txValid_reg;
  logic [7:0] txData_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      txLeft_reg <= 2'd0;
      txBuf_reg[0] <= 8'h00;
      txBuf_reg[1] <= 8'h00;
      txBuf_reg[2] <= 8'h00;
      txValid_reg <= 1'b0;
      txData_reg <= 8'h00;
    end else begin
      txValid_reg <= 1'b0;
      if (loadErr) begin
        txBuf_reg[0] <= `ILPC_ERR_LEN;
        txBuf_reg[1] <= `ILPC_ERR_LEN0;
        txLeft_reg <= 2'd2;
      end else if (loadWake) begin
        txBuf_reg[0] <= `ILPC_RES_OK;
        txBuf_reg[1] <= `ILPC_RES_LEN1;
        txBuf_reg[2] <= wakeFlag;
        txLeft_reg <= 2'd3;
      end else if (txLeft_reg != 2'd0) begin
        txValid_reg <= 1'b1;
        txData_reg <= txBuf_reg[0];
        txBuf_reg[0] <= txBuf_reg[1];
        txBuf_reg[1] <= txBuf_reg[2];
        txLeft_reg <= txLeft_reg - 2'd1;
      end
    end
  end

  assign link.dToHValid = txValid_reg;
  assign link.dToHData = txData_reg;

  // ****************************************
  // status and resource outputs
  // ****************************************
  logic ready_reg, low_reg, hibOut_reg, fdOn_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      ready_reg <= 1'b0;
      low_reg <= 1'b1;
      hibOut_reg <= 1'b0;
      fdOn_reg <= 1'b0;
    end else begin
      ready_reg <= state_reg != DEV_PWRUP && state_reg != DEV_START &&
        state_reg != DEV_WAIT;
      low_reg <= state_reg == DEV_PWRUP || state_reg == DEV_WAIT;
      hibOut_reg <= state_reg == DEV_WAIT && hib_reg;
      // detector powered in sleep only when it may wake us
      fdOn_reg <= state_reg == DEV_WAIT ? (fieldEn & ~hib_reg) : 1'b1;
    end
  end

  assign hostReady = ready_reg;
  assign lowPower = low_reg;
  assign hibernate = hibOut_reg;
  assign fieldDetOn = fdOn_reg;
  assign wakeSource = data_reg[0];
  assign entrySetting = {data_reg[1], data_reg[2]};
  assign wakeSetting = {data_reg[3], data_reg[4]};
  assign leaveSetting = {data_reg[5], data_reg[6]};
  assign extraParams = {data_reg[7], data_reg[8], data_reg[9], data_reg[10],
    data_reg[11], data_reg[12], data_reg[13]};
endmodule
`default_nettype wire

// ---- hdl/ilpc_host.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "ilpc_regs.svh"
module ilpc_host
  import ilpc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  ilpc_link_if.host link,
  input wire logic [7:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [31:0] rdData,
  output logic irq
);
  // ****************************************
  // settings registers
  // ****************************************
  logic [7:0] wsrc_reg, extra_reg;
  logic [15:0] entry_reg, wake_reg, leave_reg;
  logic [1:0] irqStat_reg, irqMask_reg;
  logic sendReq, pulseReq;

  assign sendReq = wrStb && addr == `ILPC_OFF_CTRL && wrData[`ILPC_CTRL_SEND_BIT];
  assign pulseReq = wrStb && addr == `ILPC_OFF_CTRL && wrData[`ILPC_CTRL_PULSE_BIT];

  always_ff @(posedge clk) begin
    if (rst) begin
      wsrc_reg <= `ILPC_WS_PIN;
      entry_reg <= `ILPC_ENTRY_SLEEP;
      wake_reg <= `ILPC_WAKE_SLEEP;
      leave_reg <= `ILPC_LEAVE_DEFAULT;
      extra_reg <= `ILPC_EXTRA_DEFAULT;
      irqMask_reg <= 2'h0;
    end else if (wrStb) begin
      if (addr == `ILPC_OFF_WSRC) begin
        wsrc_reg <= wrData[7:0];
      end else if (addr == `ILPC_OFF_ENTRY) begin
        entry_reg <= wrData[15:0];
      end else if (addr == `ILPC_OFF_WAKE) begin
        wake_reg <= wrData[15:0];
      end else if (addr == `ILPC_OFF_LEAVE) begin
        leave_reg <= wrData[15:0];
      end else if (addr == `ILPC_OFF_EXTRA) begin
        extra_reg <= wrData[7:0];
      end else if (addr == `ILPC_OFF_IRQ_MASK) begin
        irqMask_reg <= wrData[1:0];
      end
    end
  end

  // ****************************************
  // request sender
  // ****************************************
  ilpc_host_state_e state_reg;
  logic [3:0] idx_reg;
  logic txValid_reg;
  logic [7:0] txData_reg;
  logic sentHib_reg;
  logic [7:0] nextByte;
  logic replyDone;

  // settings go most significant byte first, as printed
  always_comb begin
    nextByte = 8'h00;
    case (idx_reg)
      4'h0: nextByte = `ILPC_CMD_IDLE;
      4'h1: nextByte = `ILPC_IDLE_LEN;
      4'h2: nextByte = wsrc_reg | `ILPC_WS_PIN;
      4'h3: nextByte = entry_reg[15:8];
      4'h4: nextByte = entry_reg[7:0];
      4'h5: nextByte = wake_reg[15:8];
      4'h6: nextByte = wake_reg[7:0];
      4'h7: nextByte = leave_reg[15:8];
      4'h8: nextByte = leave_reg[7:0];
      4'ha: nextByte = extra_reg;
      default: nextByte = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= HST_IDLE;
      idx_reg <= 4'h0;
      txValid_reg <= 1'b0;
      txData_reg <= 8'h00;
      sentHib_reg <= 1'b1;
    end else begin
      txValid_reg <= 1'b0;
      case (state_reg)
        HST_IDLE: begin
          if (sendReq) begin
            state_reg <= HST_SEND;
            idx_reg <= 4'h0;
            sentHib_reg <= entry_reg == `ILPC_ENTRY_HIBERNATE;
          end
        end
        HST_SEND: begin
          txValid_reg <= 1'b1;
          txData_reg <= nextByte;
          idx_reg <= idx_reg + 4'h1;
          if (idx_reg == 4'hf) begin
            state_reg <= HST_WAIT;
          end
        end
        HST_WAIT: begin
          if (replyDone) begin
            state_reg <= HST_IDLE;
          end
        end
        default: begin
          state_reg <= HST_IDLE;
        end
      endcase
    end
  end

  assign link.hToDValid = txValid_reg;
  assign link.hToDData = txData_reg;

  // ****************************************
  // wake pin pulse
  // ****************************************
  logic [3:0] pulseCnt_reg;
  logic pin_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      pulseCnt_reg <= 4'h0;
      pin_reg <= 1'b1;
    end else if (pulseReq && pulseCnt_reg == 4'h0) begin
      pulseCnt_reg <= 4'(`ILPC_WAKE_PULSE_CYC);
      pin_reg <= 1'b0;
    end else if (pulseCnt_reg != 4'h0) begin
      pulseCnt_reg <= pulseCnt_reg - 4'h1;
      pin_reg <= pulseCnt_reg == 4'h1;
    end
  end

  assign link.wakeReqN = pin_reg;

  // ****************************************
  // reply receiver
  // ****************************************
  logic [1:0] rxIdx_reg;
  logic [7:0] code_reg, flag_reg;
  logic flagValid_reg;

  assign replyDone = link.dToHValid &&
    ((rxIdx_reg == 2'd1 && link.dToHData == 8'h00) || rxIdx_reg == 2'd2);

  always_ff @(posedge clk) begin
    if (rst) begin
      rxIdx_reg <= 2'd0;
      code_reg <= 8'h00;
      flag_reg <= 8'h00;
      flagValid_reg <= 1'b0;
    end else if (link.dToHValid) begin
      rxIdx_reg <= replyDone ? 2'd0 : rxIdx_reg + 2'd1;
      if (rxIdx_reg == 2'd0) begin
        code_reg <= link.dToHData;
      end
      if (rxIdx_reg == 2'd2) begin
        flag_reg <= link.dToHData;
        flagValid_reg <= ~sentHib_reg;
      end
    end
  end

  // ****************************************
  // interrupts and read port
  // ****************************************
  logic [1:0] irqSet;
  logic irq_reg;

  assign irqSet = {replyDone && code_reg == `ILPC_ERR_LEN,
    replyDone && code_reg == `ILPC_RES_OK};

  // a new event beats a simultaneous clear
  always_ff @(posedge clk) begin
    if (rst) begin
      irqStat_reg <= 2'h0;
    end else if (wrStb && addr == `ILPC_OFF_IRQ_STAT) begin
      irqStat_reg <= (irqStat_reg & ~wrData[1:0]) | irqSet;
    end else begin
      irqStat_reg <= irqStat_reg | irqSet;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irqStat_reg & irqMask_reg);
    end
  end

  assign irq = irq_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      rdData <= 32'h00000000;
    end else if (rdStb) begin
      if (addr == `ILPC_OFF_WSRC) begin
        rdData <= {24'h000000, wsrc_reg};
      end else if (addr == `ILPC_OFF_ENTRY) begin
        rdData <= {16'h0000, entry_reg};
      end else if (addr == `ILPC_OFF_WAKE) begin
        rdData <= {16'h0000, wake_reg};
      end else if (addr == `ILPC_OFF_LEAVE) begin
        rdData <= {16'h0000, leave_reg};
      end else if (addr == `ILPC_OFF_EXTRA) begin
        rdData <= {24'h000000, extra_reg};
      end else if (addr == `ILPC_OFF_STATUS) begin
        rdData <= {13'h0000, flagValid_reg, state_reg, code_reg, flag_reg};
      end else if (addr == `ILPC_OFF_IRQ_STAT) begin
        rdData <= {30'h00000000, irqStat_reg};
      end else if (addr == `ILPC_OFF_IRQ_MASK) begin
        rdData <= {30'h00000000, irqMask_reg};
      end else begin
        rdData <= 32'h00000000;
      end
    end else begin
      rdData <= 32'h00000000;
    end
  end
endmodule
`default_nettype wire

// ---- tb/ilpc_link_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****
// wire checks on the host-device link
// ****
module ilpc_link_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic hToDValid,
  input wire logic [7:0] hToDData,
  input wire logic dToHValid,
  input wire logic [7:0] dToHData,
  input wire logic wakeReqN
);
  logic [4:0] hCnt;
  logic [1:0] dCnt;
  logic armed;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // byte index within a host frame
  always_ff @(posedge clk) begin
    if (rst || !hToDValid) begin
      hCnt <= 5'h00;
    end else begin
      hCnt <= hCnt + 5'h01;
    end
  end
  // byte index within a device reply
  always_ff @(posedge clk) begin
    if (rst || !dToHValid) begin
      dCnt <= 2'h0;
    end else begin
      dCnt <= dCnt + 2'h1;
    end
  end
  // full request sent, reply still owed
  always_ff @(posedge clk) begin
    if (rst || dToHValid) begin
      armed <= 1'b0;
    end else if (hToDValid && hCnt == 5'h0f) begin
      armed <= 1'b1;
    end
  end
  a_cmd_code: assert property (hToDValid && hCnt == 5'h00 |-> hToDData == 8'h07)
    else $error("frame does not open with the idle code");
  a_len_byte: assert property (hToDValid && hCnt == 5'h01 |-> hToDData == 8'h0e)
    else $error("length byte wrong");
  a_frame_whole: assert property (hToDValid && hCnt < 5'h0f |=> hToDValid)
    else $error("frame broken off early");
  a_frame_end: assert property (hToDValid && hCnt == 5'h0f |=> !hToDValid)
    else $error("frame longer than sixteen bytes");
  a_pin_enabled: assert property (hToDValid && hCnt == 5'h02 |-> hToDData[3])
    else $error("wake pin source not enabled");
  a_no_early: assert property (hToDValid && hCnt == 5'h0f |=> !dToHValid [*3])
    else $error("reply came before wake");
  a_reply_shape: assert property (dToHValid && dCnt == 2'h0 && dToHData == 8'h00
    |=> dToHValid && dToHData == 8'h01 ##1 dToHValid && (dToHData == 8'h04 ||
    dToHData == 8'h08) ##1 !dToHValid)
    else $error("wake reply malformed");
  a_first_code: assert property (dToHValid && dCnt == 2'h0 |->
    dToHData == 8'h00 || dToHData == 8'h82)
    else $error("unknown reply code");
  a_pulse_width: assert property ($fell(wakeReqN) |-> !wakeReqN [*8] ##1 wakeReqN)
    else $error("wake pulse width wrong");
  a_pin_wake: assert property (armed && $rose(wakeReqN) |->
    ##[2:12] (dToHValid && dCnt == 2'h0 && dToHData == 8'h00))
    else $error("pin pulse did not wake");
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk, rst, wrStb, rdStb, irq, fieldPresent;
  logic [7:0] addr;
  logic [31:0] wrData, rdData;
  logic hostReady, lowPower, hibernate, fieldDetOn;
  logic [7:0] wakeSource;
  logic [15:0] entrySetting, wakeSetting, leaveSetting;
  logic [55:0] extraParams;
  integer err_total, n_compared, seed;
  logic [7:0] rq[$];
  ilpc_link_if link();
  ilpc_link_if linkErr();
  ilpc_host u_ilpc_host (.clk(clk), .rst(rst), .link(link), .addr(addr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .irq(irq));
  ilpc_device #(.STARTUP_CYCLES(16)) u_ilpc_device (.clk(clk), .rst(rst), .link(link),
    .fieldPresent(fieldPresent), .hostReady(hostReady), .lowPower(lowPower),
    .hibernate(hibernate), .fieldDetOn(fieldDetOn), .wakeSource(wakeSource),
    .entrySetting(entrySetting), .wakeSetting(wakeSetting), .leaveSetting(leaveSetting),
    .extraParams(extraParams));
  // second device faces the bench, which breaks the framing on purpose
  ilpc_device #(.STARTUP_CYCLES(16)) u_ilpc_device_err (.clk(clk), .rst(rst),
    .link(linkErr), .fieldPresent(1'b0), .hostReady(), .lowPower(), .hibernate(),
    .fieldDetOn(), .wakeSource(), .entrySetting(), .wakeSetting(), .leaveSetting(),
    .extraParams());
  ilpc_link_properties u_ilpc_link_properties (.clk(clk), .rst(rst),
    .hToDValid(link.hToDValid), .hToDData(link.hToDData), .dToHValid(link.dToHValid),
    .dToHData(link.dToHData), .wakeReqN(link.wakeReqN));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (linkErr.dToHValid === 1'b1) begin
      rq.push_back(linkErr.dToHData);
    end
  end
  // ****
  // helpers
  // ****
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // settle after the edge so flags are read once updated
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    #1;
    d = rdData;
  endtask
  task automatic waitLp(input logic lvl);
    for (int i = 0; i < 200 && lowPower !== lvl; i++) cyc(1);
    chk("lowPower", lvl, lowPower);
  endtask
  task automatic errFrame(input logic [7:0] c, input logic [7:0] n, input int nExp);
    rq.delete();
    @(posedge clk);
    linkErr.hToDValid <= 1'b1;
    linkErr.hToDData <= c;
    @(posedge clk);
    linkErr.hToDData <= n;
    for (int k = 0; k < n; k++) begin
      @(posedge clk);
      linkErr.hToDData <= 8'($random(seed));
    end
    @(posedge clk);
    linkErr.hToDValid <= 1'b0;
    linkErr.hToDData <= ~linkErr.hToDData;
    cyc(20);
    chk("errReplyLen", nExp, rq.size());
    if (nExp == 2 && rq.size() == 2) begin
      chk("errReply", 16'h8200, {rq[0], rq[1]});
    end
  endtask
  function automatic logic [31:0] expStatus(input logic hib, input logic fld);
    return {13'h0, !hib, 2'b00, 8'h00, hib ? 8'h00 : (fld ? 8'h04 : 8'h08)};
  endfunction
  initial begin
    cyc(20000);
    err_total++;
    $display("MISMATCH watchdog expected done seen timeout");
    tally_and_finish();
  end
  // ****
  // main sequence
  // ****
  initial begin
    static logic [7:0] ro[7] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h44};
    static logic [31:0] rv[7] = '{32'h08, 32'h0100, 32'h3800, 32'h1800, 32'h60, 32'h0, 32'h0};
    static logic [7:0] wsT[6] = '{8'h08, 8'h08, 8'h04, 8'h0a, 8'h0a, 8'h04};
    static logic [15:0] enT[6] = '{16'h0400, 16'h0100, 16'h0142, 16'h0142, 16'h0142, 16'h0142};
    static logic [5:0] fdT = 6'b001100;
    logic [31:0] v, r;
    logic [7:0] ws, ex;
    logic [15:0] en;
    logic hib, fld, m;
    seed = 32'h2be9;
    err_total = 0;
    n_compared = 0;
    rst = 1'b1;
    addr = 8'h00;
    wrData = 32'h0;
    wrStb = 1'b0;
    rdStb = 1'b0;
    fieldPresent = 1'b0;
    linkErr.hToDValid = 1'b0;
    linkErr.hToDData = 8'h00;
    linkErr.wakeReqN = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd(ro[i], v);
      chk("regReset", rv[i], v);
    end
    chk("leaveDefault", 16'h1800, leaveSetting);
    chk("lowPower", 1'b1, lowPower);
    errFrame(8'h07, 8'h00, 0);
    @(posedge clk);
    linkErr.wakeReqN <= 1'b0;
    wr(8'h00, 32'h2);
    repeat (7) @(posedge clk);
    linkErr.wakeReqN <= 1'b1;
    cyc(7);
    chk("hostReady", 1'b0, hostReady);
    for (int i = 0; i < 60 && hostReady !== 1'b1; i++) cyc(1);
    chk("hostReady", 1'b1, hostReady);
    chk("lowPower", 1'b0, lowPower);
    for (int i = 0; i < 6; i++) begin
      ws = wsT[i];
      en = enT[i];
      fld = fdT[i];
      r = $random(seed);
      ex = r[15:8];
      m = r[2];
      if (i == 5) begin
        ws = r[0] ? 8'h04 : 8'h0a;
        fld = r[1];
      end
      hib = (en == 16'h0400);
      wr(8'h04, {24'h0, ws});
      wr(8'h08, {16'h0, en});
      wr(8'h0c, hib ? 32'h0400 : 32'h3800);
      wr(8'h10, 32'h1800);
      wr(8'h14, {24'h0, ex});
      wr(8'h20, {31'h0, m});
      wr(8'h00, 32'h1);
      waitLp(1'b1);
      cyc(3);
      chk("wakeSource", ws | 8'h08, wakeSource);
      chk("entrySetting", en, entrySetting);
      chk("wakeSetting", hib ? 16'h0400 : 16'h3800, wakeSetting);
      chk("leaveSetting", 16'h1800, leaveSetting);
      chk("extraParams", {8'h00, ex, 40'h0}, extraParams);
      chk("hibernate", hib, hibernate);
      chk("fieldDetOn", !hib && (ws[2] | ws[1]), fieldDetOn);
      rd(8'h18, v);
      chk("hostState", 2'h2, v[17:16]);
      if (hib) begin
        @(posedge clk);
        fieldPresent <= 1'b1;
        cyc(20);
        chk("lowPower", 1'b1, lowPower);
        @(posedge clk);
        fieldPresent <= 1'b0;
        cyc(4);
      end
      if (fld) begin
        @(posedge clk);
        fieldPresent <= 1'b1;
      end else begin
        wr(8'h00, 32'h2);
      end
      waitLp(1'b0);
      @(posedge clk);
      fieldPresent <= 1'b0;
      cyc(10);
      rd(8'h18, v);
      chk("status", expStatus(hib, fld), hib ? v & 32'h0007ff00 : v);
      chk("irq", m, irq);
      rd(8'h1c, v);
      chk("irqStat", 32'h1, v);
      wr(8'h20, 32'h1);
      cyc(3);
      chk("irq", 1'b1, irq);
      wr(8'h1c, 32'h1);
      cyc(3);
      chk("irq", 1'b0, irq);
    end
    errFrame(8'h07, 8'h00, 2);
    errFrame(8'h05, 8'h02, 0);
    errFrame(8'h07, 8'h03, 2);
    tally_and_finish();
  end
endmodule
`default_nettype wire
